// [common/crm_pkg.sv]
// Shared constants and types for the cyclic run mode controller
package crm_pkg;
  localparam int AWO_BITS = 96;
  localparam int ISO_BITS = 128;
  localparam int PE_BITS = 16;

  typedef enum logic [1:0] {MODE_RUN, MODE_DEEP_STOP, MODE_CYC_RUN, MODE_CYC_STOP} crm_mode_e;

  // Retention RAM base, value arbitrary; handler offsets are fixed
  localparam logic [31:0] RRAM_BASE_ADDR = 32'h1000_0000;
  localparam logic [31:0] FATAL_NMI_OFFSET = 32'h0000_00E0;
  localparam logic [31:0] FATAL_INT_OFFSET = 32'h0000_00F0;

  // Peripheral enable vector bit positions
  localparam int PE_AWO_PORT = 0;
  localparam int PE_ISO_PORT = 1;
  localparam int PE_LPS = 2;
  localparam int PE_EXTERNAL_CLOCK_OUTPUT = 3;
  localparam int PE_RRAM = 4;
  localparam int PE_AWO_WDT = 5;
  localparam int PE_WDT0 = 6;
  localparam int PE_SWDT = 7;
  localparam int PE_TIMER = 8;
  localparam int PE_RTC = 9;
  localparam int PE_LIN = 10;
  localparam int PE_MULTICHANNEL_SPI = 11;
  localparam int PE_CLKMON = 12;
  localparam int PE_ECM = 13;
  localparam int PE_ECM_DLY = 14;
  localparam int PE_ADC = 15;

  // Per-mode peripheral enable patterns
  localparam logic [PE_BITS-1:0] PE_RUN = 16'hFFFF;
  localparam logic [PE_BITS-1:0] PE_CYC_RUN = 16'hBFFD;
  localparam logic [PE_BITS-1:0] PE_CYC_STOP = 16'hB73D;
  localparam logic [PE_BITS-1:0] PE_DEEP_STOP = 16'h933D;
endpackage

// [verilog/crm_sync.sv]
// Two-stage synchroniser for asynchronous wake-up inputs
`timescale 1ns/1ns
module crm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in, // Always-on clock
  input wire logic rst_in, // Synchronous reset, high
  input wire logic [WIDTH-1:0] async_in, // Unsynchronised levels
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// [verilog/crm_wake_bank.sv]
// Wake-up flag bank with mask and write-one-to-clear
`timescale 1ns/1ns
module crm_wake_bank #(
  parameter int WIDTH = 96
) (
  input wire logic clk_in, // Always-on clock
  input wire logic rst_in, // Synchronous reset, high
  input wire logic [WIDTH-1:0] src_in, // Synchronised source levels
  input wire logic [WIDTH-1:0] mask_in, // 1 = source masked
  input wire logic [WIDTH-1:0] clear_in, // Write-one-to-clear pulses
  output logic [WIDTH-1:0] flags_out, // Sticky wake flags
  output logic event_out // Any unmasked source active
);
  logic [WIDTH-1:0] set_vec;

  assign set_vec = src_in & ~mask_in;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_flag
      // Set beats clear so a coincident wake is never lost
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          flags_out[i] <= 1'b0;
        else if (set_vec[i])
          flags_out[i] <= 1'b1;
        else if (clear_in[i])
          flags_out[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      event_out <= 1'b0;
    else
      event_out <= |set_vec;
  end

  AST_FLAG_SET: assert property (@(posedge clk_in) disable iff (rst_in)
    (set_vec != '0) |=> ((flags_out & $past(set_vec)) == $past(set_vec)))
    else $error("Unmasked wake source did not set its flag");

  AST_MASKED_QUIET: assert property (@(posedge clk_in) disable iff (rst_in)
    (set_vec == '0) |=> !event_out)
    else $error("Wake event raised with all sources masked");

  AST_CLEAR_WORKS: assert property (@(posedge clk_in) disable iff (rst_in)
    (clear_in != '0) |=> ((flags_out & $past(clear_in) & ~$past(set_vec)) == '0))
    else $error("Clear write left a flag set");

  AST_FLAG_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    (clear_in == '0) |=> ((flags_out & $past(flags_out)) == $past(flags_out)))
    else $error("Flag dropped without a clear");
endmodule

// [verilog/crm_controller.sv]
// Cyclic run / cyclic stop mode controller in the always-on domain
`timescale 1ns/1ns
module crm_controller
  import crm_pkg::*;
(
  input wire logic REF_CLK_IN, // Always-on clock, 125 MHz
  input wire logic RST_IN, // Synchronous reset, high
  input wire logic [crm_pkg::AWO_BITS-1:0] WAKE1_SRC_AWO_IN, // Group 1 always-on sources
  input wire logic [crm_pkg::ISO_BITS-1:0] WAKE1_SRC_ISO_IN, // Group 1 isolated sources
  input wire logic WAKE0_EVENT_IN, // Masked group 0 wake request
  input wire logic [crm_pkg::AWO_BITS-1:0] WAKE_GROUP1_MASK_AWO_IN, // 1 = masked
  input wire logic [crm_pkg::ISO_BITS-1:0] WAKE_GROUP1_MASK_ISO_IN, // 1 = masked
  input wire logic [crm_pkg::AWO_BITS-1:0] WAKE_GROUP1_CLEAR_AWO_IN, // Clear pulses
  input wire logic [crm_pkg::ISO_BITS-1:0] WAKE_GROUP1_CLEAR_ISO_IN, // Clear pulses
  input wire logic CYCLIC_STOP_TRIGGER_IN, // Write-one pulse
  input wire logic DEEP_STOP_TRIGGER_IN, // Write-one pulse
  input wire logic FATAL_NONMASKABLE_EXCEPTION_IN, // Fatal NMI pulse
  input wire logic FATAL_MASKABLE_EXCEPTION_IN, // Fatal interrupt pulse
  output crm_pkg::crm_mode_e MODE_OUT, // Current operating mode
  output logic [crm_pkg::AWO_BITS-1:0] WAKE_GROUP1_FLAGS_AWO_OUT, // Sticky flags
  output logic [crm_pkg::ISO_BITS-1:0] WAKE_GROUP1_FLAGS_ISO_OUT, // Sticky flags
  output logic PLL_EN_OUT, // PLL available
  output logic FLASH_EN_OUT, // Code and data flash available
  output logic PRIMARY_CORE_EN_OUT, // Primary core clocked
  output logic OTHER_CORES_EN_OUT, // Secondary cores clocked
  output logic RRAM_FETCH_OUT, // Primary core fetches from retention RAM
  output logic [crm_pkg::PE_BITS-1:0] PERIPH_EN_OUT, // Peripheral clock enables
  output logic RESTART_OUT, // One-cycle restart request
  output logic [31:0] RESTART_ADDR_OUT // Restart fetch address
);
  import crm_pkg::*;

  localparam int SYNC_BITS = AWO_BITS + ISO_BITS + 1;

  logic [SYNC_BITS-1:0] sync_lvl;
  logic [AWO_BITS-1:0] awo_src;
  logic [ISO_BITS-1:0] iso_src;
  logic g0_lvl;
  logic g1_awo_evt;
  logic g1_iso_evt;
  logic g1_evt_deep;
  logic g1_evt_cstop;
  logic nmi_pending;
  logic int_pending;
  logic leave_deep;
  logic enter_cyc_from_deep;
  crm_mode_e next_mode;
  logic [31:0] next_restart_addr;

  crm_sync #(
    .WIDTH(SYNC_BITS)
  ) u_sync (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .async_in({WAKE0_EVENT_IN, WAKE1_SRC_ISO_IN, WAKE1_SRC_AWO_IN}),
    .sync_out(sync_lvl)
  );

  assign awo_src = sync_lvl[AWO_BITS-1:0];
  assign iso_src = sync_lvl[AWO_BITS+ISO_BITS-1:AWO_BITS];
  assign g0_lvl = sync_lvl[SYNC_BITS-1];

  crm_wake_bank #(
    .WIDTH(AWO_BITS)
  ) u_bank_awo (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .src_in(awo_src),
    .mask_in(WAKE_GROUP1_MASK_AWO_IN),
    .clear_in(WAKE_GROUP1_CLEAR_AWO_IN),
    .flags_out(WAKE_GROUP1_FLAGS_AWO_OUT),
    .event_out(g1_awo_evt)
  );

  crm_wake_bank #(
    .WIDTH(ISO_BITS)
  ) u_bank_iso (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .src_in(iso_src),
    .mask_in(WAKE_GROUP1_MASK_ISO_IN),
    .clear_in(WAKE_GROUP1_CLEAR_ISO_IN),
    .flags_out(WAKE_GROUP1_FLAGS_ISO_OUT),
    .event_out(g1_iso_evt)
  );

  // Isolated sources are unpowered in deep stop, so only always-on ones count there
  assign g1_evt_deep = g1_awo_evt;
  assign g1_evt_cstop = g1_awo_evt | g1_iso_evt;
  assign enter_cyc_from_deep = (MODE_OUT == MODE_DEEP_STOP) && g1_evt_deep;
  assign leave_deep = (MODE_OUT == MODE_DEEP_STOP) && (g1_evt_deep || g0_lvl);

  // Mode sequencing; deep stop trigger outranks cyclic stop trigger
  always_comb
  begin
    next_mode = MODE_OUT;
    case (MODE_OUT)
      MODE_RUN:
      begin
        if (DEEP_STOP_TRIGGER_IN)
          next_mode = MODE_DEEP_STOP;
      end
      MODE_DEEP_STOP:
      begin
        if (g1_evt_deep)
          next_mode = MODE_CYC_RUN;
        else if (g0_lvl)
          next_mode = MODE_RUN;
      end
      MODE_CYC_RUN:
      begin
        // Normal run is never entered directly from here
        if (DEEP_STOP_TRIGGER_IN)
          next_mode = MODE_DEEP_STOP;
        else if (CYCLIC_STOP_TRIGGER_IN)
          next_mode = MODE_CYC_STOP;
      end
      MODE_CYC_STOP:
      begin
        if (g0_lvl || g1_evt_cstop)
          next_mode = MODE_CYC_RUN;
      end
      default:
        next_mode = MODE_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      MODE_OUT <= MODE_RUN;
    else
      MODE_OUT <= next_mode;
  end

  // Fatal exception memory; a new exception beats the clear on exit
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      nmi_pending <= 1'b0;
      int_pending <= 1'b0;
    end
    else
    begin
      if (FATAL_NONMASKABLE_EXCEPTION_IN)
        nmi_pending <= 1'b1;
      else if (leave_deep)
        nmi_pending <= 1'b0;
      if (FATAL_MASKABLE_EXCEPTION_IN)
        int_pending <= 1'b1;
      else if (leave_deep)
        int_pending <= 1'b0;
    end
  end

  // Fatal NMI handler takes precedence over fatal interrupt handler
  always_comb
  begin
    if (nmi_pending)
      next_restart_addr = RRAM_BASE_ADDR + FATAL_NMI_OFFSET;
    else if (int_pending)
      next_restart_addr = RRAM_BASE_ADDR + FATAL_INT_OFFSET;
    else
      next_restart_addr = RRAM_BASE_ADDR;
  end

  // Cyclic stop exit resumes in place, so only a group 1 wake out of deep stop into cyclic run restarts
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      RESTART_OUT <= 1'b0;
      RESTART_ADDR_OUT <= RRAM_BASE_ADDR;
    end
    else
    begin
      RESTART_OUT <= enter_cyc_from_deep;
      if (enter_cyc_from_deep)
        RESTART_ADDR_OUT <= next_restart_addr;
    end
  end

  // Clock gates follow next_mode so they change with MODE_OUT
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      PLL_EN_OUT <= 1'b1;
      FLASH_EN_OUT <= 1'b1;
      PRIMARY_CORE_EN_OUT <= 1'b1;
      OTHER_CORES_EN_OUT <= 1'b1;
      RRAM_FETCH_OUT <= 1'b0;
      PERIPH_EN_OUT <= PE_RUN;
    end
    else
    begin
      PLL_EN_OUT <= (next_mode == MODE_RUN);
      FLASH_EN_OUT <= (next_mode == MODE_RUN);
      PRIMARY_CORE_EN_OUT <= (next_mode == MODE_RUN) || (next_mode == MODE_CYC_RUN);
      OTHER_CORES_EN_OUT <= (next_mode == MODE_RUN);
      RRAM_FETCH_OUT <= (next_mode == MODE_CYC_RUN);
      case (next_mode)
        MODE_CYC_RUN: PERIPH_EN_OUT <= PE_CYC_RUN;
        MODE_CYC_STOP: PERIPH_EN_OUT <= PE_CYC_STOP;
        MODE_DEEP_STOP: PERIPH_EN_OUT <= PE_DEEP_STOP;
        default: PERIPH_EN_OUT <= PE_RUN;
      endcase
    end
  end

  sequence s_deep_g1_wake;
    (MODE_OUT == MODE_DEEP_STOP) && g1_evt_deep;
  endsequence

  sequence s_enter_cyc_run;
    (MODE_OUT == MODE_CYC_RUN) && RRAM_FETCH_OUT && RESTART_OUT;
  endsequence

  sequence s_cyc_run_gated;
    (MODE_OUT == MODE_CYC_RUN) && !PLL_EN_OUT && !FLASH_EN_OUT;
  endsequence

  AST_DEEP_TO_CYC: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_deep_g1_wake |=> s_enter_cyc_run)
    else $error("Group 1 wake in deep stop did not restart cyclic run");

  AST_DEEP_NEEDS_G1: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    ((MODE_OUT == MODE_DEEP_STOP) && !g1_evt_deep) |=> (MODE_OUT != MODE_CYC_RUN))
    else $error("Cyclic run entered from deep stop without group 1 wake");

  AST_CSTOP_WAKE: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    ((MODE_OUT == MODE_CYC_STOP) && (g0_lvl || g1_evt_cstop)) |=> ((MODE_OUT == MODE_CYC_RUN) && !RESTART_OUT))
    else $error("Cyclic stop did not resume cyclic run on wake");

  AST_RESTART_ADDR: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (s_deep_g1_wake and (!nmi_pending && !int_pending)) |=> (RESTART_ADDR_OUT == RRAM_BASE_ADDR))
    else $error("Plain restart not at retention RAM base");

  AST_FATAL_NMI_ADDR: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (s_deep_g1_wake and nmi_pending) |=> (RESTART_ADDR_OUT == RRAM_BASE_ADDR + FATAL_NMI_OFFSET))
    else $error("Fatal NMI restart address wrong");

  AST_FATAL_INT_ADDR: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (s_deep_g1_wake and (!nmi_pending && int_pending)) |=> (RESTART_ADDR_OUT == RRAM_BASE_ADDR + FATAL_INT_OFFSET))
    else $error("Fatal interrupt restart address wrong");

  AST_CSTOP_TRIG: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    ((MODE_OUT == MODE_CYC_RUN) && CYCLIC_STOP_TRIGGER_IN && !DEEP_STOP_TRIGGER_IN)
      |=> ((MODE_OUT == MODE_CYC_STOP) && !PRIMARY_CORE_EN_OUT))
    else $error("Cyclic stop trigger ignored");

  AST_DSTOP_TRIG: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    ((MODE_OUT == MODE_CYC_RUN) && DEEP_STOP_TRIGGER_IN) |=> (MODE_OUT == MODE_DEEP_STOP))
    else $error("Deep stop trigger ignored in cyclic run");

  AST_NO_DIRECT_RUN: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (MODE_OUT == MODE_CYC_RUN) |=> (MODE_OUT != MODE_RUN))
    else $error("Cyclic run went straight to normal run");

  AST_CYC_RUN_CORES: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (MODE_OUT == MODE_CYC_RUN) |-> s_cyc_run_gated ##0 (PRIMARY_CORE_EN_OUT && !OTHER_CORES_EN_OUT))
    else $error("Cyclic run clock gating wrong");

  AST_CYC_PERIPH: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (MODE_OUT == MODE_CYC_STOP) |-> (PERIPH_EN_OUT == PE_CYC_STOP) && !PERIPH_EN_OUT[PE_ECM_DLY]
      && PERIPH_EN_OUT[PE_ECM])
    else $error("Cyclic stop peripheral enables wrong");
endmodule

// [test/crm_controller_tb.sv]
// Self-checking testbench for the cyclic run mode controller
`timescale 1ns/1ns
module crm_controller_tb;
  import crm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [AWO_BITS-1:0] src_awo = '0, mask_awo = '1, clr_awo = '0, flags_awo;
  logic [ISO_BITS-1:0] src_iso = '0, mask_iso = '1, clr_iso = '0, flags_iso;
  logic wake0 = 1'b0, cyc_trig = 1'b0, deep_trig = 1'b0, fat_nmi = 1'b0, fat_int = 1'b0;
  logic pll_en, flash_en, core_en, others_en, rram_fetch, restart;
  logic [PE_BITS-1:0] periph;
  logic [31:0] restart_addr;
  crm_mode_e mode;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int restarts = 0;
  int r;

  crm_controller crm_controller_i (.REF_CLK_IN(ref_clk), .RST_IN(rst), .WAKE1_SRC_AWO_IN(src_awo),
    .WAKE1_SRC_ISO_IN(src_iso), .WAKE0_EVENT_IN(wake0), .WAKE_GROUP1_MASK_AWO_IN(mask_awo),
    .WAKE_GROUP1_MASK_ISO_IN(mask_iso), .WAKE_GROUP1_CLEAR_AWO_IN(clr_awo),
    .WAKE_GROUP1_CLEAR_ISO_IN(clr_iso), .CYCLIC_STOP_TRIGGER_IN(cyc_trig), .DEEP_STOP_TRIGGER_IN(deep_trig),
    .FATAL_NONMASKABLE_EXCEPTION_IN(fat_nmi), .FATAL_MASKABLE_EXCEPTION_IN(fat_int), .MODE_OUT(mode),
    .WAKE_GROUP1_FLAGS_AWO_OUT(flags_awo), .WAKE_GROUP1_FLAGS_ISO_OUT(flags_iso), .PLL_EN_OUT(pll_en),
    .FLASH_EN_OUT(flash_en), .PRIMARY_CORE_EN_OUT(core_en), .OTHER_CORES_EN_OUT(others_en),
    .RRAM_FETCH_OUT(rram_fetch), .PERIPH_EN_OUT(periph), .RESTART_OUT(restart),
    .RESTART_ADDR_OUT(restart_addr));

  always #4 ref_clk = ~ref_clk;

  // Restart pulses last one cycle, so count them at every edge
  always @(posedge ref_clk)
  begin
    cycles++;
    if (restart === 1'b1)
      restarts++;
    if (cycles >= 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait: group 1 wake path takes four edges through the synchroniser, group 0 three
  task wait_mode(input crm_mode_e m);
    int n;
    n = 0;
    while (mode !== m && n < 12)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(mode, m);
  endtask

  task trig(input bit deep);
    if (deep)
      deep_trig = 1'b1;
    else
      cyc_trig = 1'b1;
    @(negedge ref_clk);
    deep_trig = 1'b0;
    cyc_trig = 1'b0;
  endtask

  // Settle after release so a stale synced level cannot re-wake
  task wake(input bit g0, input crm_mode_e m);
    if (g0)
      wake0 = 1'b1;
    else
      src_awo[7] = 1'b1;
    wait_mode(m);
    wake0 = 1'b0;
    src_awo[7] = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  task check_cyc_run();
    chk({pll_en, flash_en}, 2'b00);
    chk({core_en, others_en, rram_fetch}, 3'b101);
    chk(periph, PE_CYC_RUN);
    chk(periph[PE_MULTICHANNEL_SPI], 1'b1);
    chk({periph[PE_ECM], periph[PE_ECM_DLY]}, 2'b10);
  endtask

  task t_reset();
    chk(mode, MODE_RUN);
    chk(periph, PE_RUN);
    chk(restart_addr, RRAM_BASE_ADDR);
    chk(flags_awo, '0);
  endtask

  // Always-on flag 7 was left set by t_fatal's group 1 wakes, so this reset must wipe it
  task t_mid_reset();
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    t_reset();
    chk(flags_iso, '0);
  endtask

  task t_deep_g1();
    trig(1'b1);
    chk(mode, MODE_DEEP_STOP);
    chk(periph, PE_DEEP_STOP);
    src_awo[3] = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(mode, MODE_DEEP_STOP);
    chk(flags_awo[3], 1'b0);
    src_awo[3] = 1'b0;
    mask_iso[5] = 1'b0;
    src_iso[5] = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(mode, MODE_DEEP_STOP);
    chk(flags_iso[5], 1'b1);
    src_iso[5] = 1'b0;
    r = restarts;
    mask_awo[7] = 1'b0;
    wake(1'b0, MODE_CYC_RUN);
    chk(restarts - r, 1);
    chk(restart_addr, RRAM_BASE_ADDR);
    chk(flags_awo[7], 1'b1);
    check_cyc_run();
  endtask

  task t_cyc_stop();
    trig(1'b0);
    chk(mode, MODE_CYC_STOP);
    chk(periph, PE_CYC_STOP);
    chk({core_en, periph[PE_MULTICHANNEL_SPI], periph[PE_WDT0], periph[PE_SWDT]}, 4'h0);
    chk({periph[PE_ECM], periph[PE_ECM_DLY]}, 2'b10);
    r = restarts;
    wake(1'b1, MODE_CYC_RUN);
    chk(restarts - r, 0);
    check_cyc_run();
    trig(1'b0);
    wake(1'b0, MODE_CYC_RUN);
    chk({flags_iso[5], flags_awo[7]}, 2'b11);
    trig(1'b0);
    src_iso[5] = 1'b1;
    wait_mode(MODE_CYC_RUN);
    src_iso[5] = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  task t_clear();
    clr_awo = ~(AWO_BITS'(1) << 7);
    @(negedge ref_clk);
    clr_awo = '0;
    @(negedge ref_clk);
    chk(flags_awo[7], 1'b1);
    clr_awo[7] = 1'b1;
    clr_iso[5] = 1'b1;
    @(negedge ref_clk);
    clr_awo = '0;
    clr_iso = '0;
    @(negedge ref_clk);
    chk(flags_awo, '0);
    chk(flags_iso, '0);
  endtask

  task automatic t_fatal();
    logic [1:0] sel [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
    logic [31:0] offs [4] = '{FATAL_NMI_OFFSET, FATAL_INT_OFFSET, FATAL_NMI_OFFSET, 32'h0};
    for (int i = 0; i < 4; i++)
    begin
      trig(1'b1);
      chk(mode, MODE_DEEP_STOP);
      {fat_nmi, fat_int} = sel[i];
      @(negedge ref_clk);
      {fat_nmi, fat_int} = 2'b00;
      r = restarts;
      wake(1'b0, MODE_CYC_RUN);
      chk(restarts - r, 1);
      chk(restart_addr, RRAM_BASE_ADDR + offs[i]);
    end
  endtask

  task t_deep_g0();
    trig(1'b1);
    r = restarts;
    wake(1'b1, MODE_RUN);
    chk({pll_en, flash_en, restarts - r}, 34'h300000000);
    trig(1'b0);
    chk(mode, MODE_RUN);
  endtask

  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    t_reset();
    t_deep_g1();
    t_cyc_stop();
    t_clear();
    t_fatal();
    t_deep_g0();
    t_mid_reset();
    print_verdict();
  end
endmodule
